// file: src/btf_unit.sv
// branch resolution, cr logic, trap test and float load/store conversion
`timescale 1ns/100ps
`default_nettype none

// Operation
// - separate single/double loads, single widened to double
// - load with update, base zero, stays valid
// - single stores narrow double register to single
// - store with update, base zero, stays valid
// - store float register low word as integer
// - branches resolved early by condition register look-ahead
// - no interlock on bit: resolve at once
// - interlock: predict statically, fetch predicted path, watch
// - interlock cleared: complete, or purge and refetch alternate
// - drop two low bits of branch targets
// - six ways to form next address
// - eight cr bit logic ops plus field move
// - cr ops wait until prior instructions complete
// - cr ops with link option are invalid
// - trap when any masked condition holds, else continue
// - register-register and immediate trap forms
module btf_unit (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              clk_en,
	// issue
	input  wire logic              op_valid,
	input  wire btf_pkg::btf_op_e  op_kind,
	output logic                   op_ready,
	// memory operand fields
	input  wire logic              op_update,
	input  wire logic [4:0]        base_gpr,
	input  wire logic [4:0]        fpr_idx,
	input  wire logic [31:0]       base_val,
	input  wire logic [31:0]       index_val,
	input  wire logic [63:0]       fpr_rdata,
	input  wire logic [63:0]       mem_rdata,
	// branch fields
	input  wire btf_pkg::btf_bform_e br_form,
	input  wire logic              br_aa,
	input  wire logic              br_lk,
	input  wire logic [4:0]        br_bit,
	input  wire logic              br_sense,
	input  wire logic [31:0]       br_disp,
	input  wire logic [31:0]       cia,
	input  wire logic [31:0]       link_register,
	input  wire logic [31:0]       count_reg,
	// condition register state
	input  wire logic [31:0]       condition_register,
	input  wire logic [31:0]       cr_busy,
	input  wire logic              prior_done,
	// cr logic fields
	input  wire btf_pkg::btf_crfn_e cr_fn,
	input  wire logic [4:0]        src_cr_a,
	input  wire logic [4:0]        src_cr_b,
	input  wire logic [4:0]        dest_cr_bit,
	// trap fields
	input  wire logic [4:0]        trap_condition_mask,
	input  wire logic              trap_imm,
	input  wire logic [15:0]       signed_immediate,
	// float register write
	output logic                   fpr_we,
	output logic [4:0]             fpr_widx,
	output logic [63:0]            fpr_wdata,
	// memory request
	output logic                   mem_rd,
	output logic                   mem_wr,
	output logic                   mem_dbl,
	output logic [31:0]            mem_addr,
	output logic [63:0]            mem_wdata,
	// base update
	output logic                   gpr_we,
	output logic [4:0]             gpr_widx,
	output logic [31:0]            gpr_wdata,
	// fetch control
	output logic                   fetch_redirect,
	output logic [31:0]            fetch_addr,
	output logic                   purge,
	output logic                   br_done,
	output logic                   lr_we,
	output logic [31:0]            lr_wdata,
	// cr write and exceptions
	output logic                   cr_we,
	output logic [31:0]            cr_wdata,
	output logic                   invalid_form,
	output logic                   trap_take
);
	typedef struct packed {
		btf_pkg::btf_state_e st;
		logic        fpr_we;
		logic [4:0]  fpr_widx;
		logic [63:0] fpr_wdata;
		logic        mem_rd;
		logic        mem_wr;
		logic        mem_dbl;
		logic [31:0] mem_addr;
		logic [63:0] mem_wdata;
		logic        gpr_we;
		logic [4:0]  gpr_widx;
		logic [31:0] gpr_wdata;
		logic        redir;
		logic [31:0] faddr;
		logic        purge;
		logic        done;
		logic        lr_we;
		logic [31:0] lr_wdata;
		logic        cr_we;
		logic [31:0] cr_wdata;
		logic        inval;
		logic        trap;
		// pending branch
		logic [4:0]  pbit;
		logic        psense;
		logic        pred;
		logic [31:0] alt;
		// pending cr op
		logic        pmove;
		btf_pkg::btf_crfn_e pfn;
		logic [4:0]  pa;
		logic [4:0]  pb;
		logic [4:0]  pd;
	} btf_state_s;

	btf_state_s s_r;
	btf_state_s s_nxt;

	// single to double widening, denormals normalised
	function automatic logic [63:0] sp_to_dp(input logic [31:0] v);
		logic [10:0] e;
		logic [22:0] m;
		logic [4:0]  lz;
		logic        hit;
		e   = 11'h000;
		m   = v[22:0];
		lz  = 5'h00;
		hit = 1'b0;
		if (v[30:23] == btf_pkg::SP_EXP_MAX) begin
			e = btf_pkg::DP_EXP_MAX;
		end else if (v[30:23] != 8'h00) begin
			e = {3'h0, v[30:23]} + btf_pkg::EXP_REBIAS;
		end else if (m != 23'h000000) begin
			for (int i = 22; i >= 0; i--) begin
				if (!hit && m[i]) begin
					hit = 1'b1;
					lz  = 5'(22 - i);
				end
			end
			m = 23'(m << (lz + 5'h01));
			e = btf_pkg::EXP_REBIAS + 11'h001 - {6'h00, lz} - 11'h001;
		end
		return {v[31], e, m, 29'h00000000};
	endfunction : sp_to_dp

	// double to single narrowing, truncating
	function automatic logic [31:0] dp_to_sp(input logic [63:0] v);
		logic [10:0] e;
		logic [23:0] dm;
		logic [31:0] r;
		e  = v[62:52];
		dm = {1'b1, v[51:29]};
		r  = {v[63], 31'h00000000};
		if (e == btf_pkg::DP_EXP_MAX) begin
			r = {v[63], btf_pkg::SP_EXP_MAX, v[51:29]};
		end else if (e > btf_pkg::SP_EXP_HI) begin
			r = {v[63], btf_pkg::SP_EXP_MAX, 23'h000000};
		end else if (e >= btf_pkg::SP_EXP_LO) begin
			r = {v[63], 8'(e - btf_pkg::EXP_REBIAS), v[51:29]};
		end else if (e >= btf_pkg::SP_DEN_LO) begin
			dm = dm >> 5'(btf_pkg::SP_EXP_LO - e);
			r  = {v[63], 8'h00, dm[22:0]};
		end
		return r;
	endfunction : dp_to_sp

	// word alignment of every target
	function automatic logic [31:0] align(input logic [31:0] a);
		return a & btf_pkg::WORD_MASK;
	endfunction : align

	function automatic logic cr_logic(
		input btf_pkg::btf_crfn_e f, input logic a, input logic b);
		logic r;
		case (f)
			btf_pkg::CL_AND:  r = a & b;
			btf_pkg::CL_ANDC: r = a & ~b;
			btf_pkg::CL_EQV:  r = ~(a ^ b);
			btf_pkg::CL_NAND: r = ~(a & b);
			btf_pkg::CL_NOR:  r = ~(a | b);
			btf_pkg::CL_OR:   r = a | b;
			btf_pkg::CL_ORC:  r = a | ~b;
			default:          r = a ^ b;
		endcase
		return r;
	endfunction : cr_logic

	logic [31:0] ea;
	logic [31:0] tgt;
	logic [31:0] seq;
	logic        cond;
	logic        take;
	logic [31:0] tb;
	logic        t_hit;
	logic [31:0] cr_nx;

	assign op_ready = (s_r.st == btf_pkg::ST_IDLE);
	assign ea       = base_val + index_val;
	assign seq      = cia + 32'h0000_0004;
	assign cond     = (br_form != btf_pkg::BF_REL) && (br_form != btf_pkg::BF_ABS);
	assign take     = !cond || (condition_register[br_bit] == br_sense);

	// target formation per form and absolute option
	always_comb begin
		case (br_form)
			btf_pkg::BF_CLR:  tgt = align(link_register);
			btf_pkg::BF_CCTR: tgt = align(count_reg);
			btf_pkg::BF_ABS,
			btf_pkg::BF_CABS: tgt = align(br_disp);
			default:          tgt = br_aa ? align(br_disp) : align(cia + br_disp);
		endcase
	end

	// trap comparison, immediate sign-extended
	always_comb begin
		tb    = trap_imm ? {{16{signed_immediate[15]}}, signed_immediate} : index_val;
		t_hit = (trap_condition_mask[btf_pkg::TO_SLT] && ($signed(base_val) < $signed(tb)))
			|| (trap_condition_mask[btf_pkg::TO_SGT] && ($signed(base_val) > $signed(tb)))
			|| (trap_condition_mask[btf_pkg::TO_EQ] && (base_val == tb))
			|| (trap_condition_mask[btf_pkg::TO_ULT] && (base_val < tb))
			|| (trap_condition_mask[btf_pkg::TO_UGT] && (base_val > tb));
	end

	// cr result of the held op
	always_comb begin
		cr_nx = condition_register;
		if (s_r.pmove) begin
			cr_nx[{s_r.pd[2:0], 2'b00} +: 4] = condition_register[{s_r.pa[2:0], 2'b00} +: 4];
		end else begin
			cr_nx[s_r.pd] = cr_logic(s_r.pfn, condition_register[s_r.pa],
				condition_register[s_r.pb]);
		end
	end

	always_comb begin
		s_nxt        = s_r;
		s_nxt.fpr_we = 1'b0;
		s_nxt.mem_rd = 1'b0;
		s_nxt.mem_wr = 1'b0;
		s_nxt.gpr_we = 1'b0;
		s_nxt.redir  = 1'b0;
		s_nxt.purge  = 1'b0;
		s_nxt.done   = 1'b0;
		s_nxt.lr_we  = 1'b0;
		s_nxt.cr_we  = 1'b0;
		s_nxt.inval  = 1'b0;
		s_nxt.trap   = 1'b0;
		case (s_r.st)
			btf_pkg::ST_IDLE: begin
				if (op_valid) begin
					s_nxt.mem_addr = ea;
					s_nxt.fpr_widx = fpr_idx;
					s_nxt.gpr_widx = base_gpr;
					s_nxt.gpr_wdata = ea;
					case (op_kind)
						btf_pkg::OP_LFD, btf_pkg::OP_LFS: begin
							s_nxt.mem_rd  = 1'b1;
							s_nxt.mem_dbl = (op_kind == btf_pkg::OP_LFD);
							s_nxt.fpr_we  = 1'b1;
							s_nxt.fpr_wdata = (op_kind == btf_pkg::OP_LFD) ? mem_rdata
								: sp_to_dp(mem_rdata[31:0]);
							// base of zero is a legal update target
							s_nxt.gpr_we  = op_update;
						end
						btf_pkg::OP_STFD, btf_pkg::OP_STFS, btf_pkg::OP_STFIW: begin
							s_nxt.mem_wr  = 1'b1;
							s_nxt.mem_dbl = (op_kind == btf_pkg::OP_STFD);
							if (op_kind == btf_pkg::OP_STFD) begin
								s_nxt.mem_wdata = fpr_rdata;
							end else if (op_kind == btf_pkg::OP_STFS) begin
								s_nxt.mem_wdata = {32'h00000000, dp_to_sp(fpr_rdata)};
							end else begin
								s_nxt.mem_wdata = {32'h00000000, fpr_rdata[31:0]};
							end
							// indexed-only form never updates
							s_nxt.gpr_we = op_update && (op_kind != btf_pkg::OP_STFIW);
						end
						btf_pkg::OP_BR: begin
							s_nxt.lr_we    = br_lk;
							s_nxt.lr_wdata = seq;
							if (!cond || !cr_busy[br_bit]) begin
								// look-ahead: resolved in the issue cycle
								s_nxt.redir = 1'b1;
								s_nxt.faddr = take ? tgt : seq;
								s_nxt.done  = 1'b1;
							end else begin
								// backward displacement predicted taken
								s_nxt.pred   = (br_form == btf_pkg::BF_CREL
									|| br_form == btf_pkg::BF_CABS) && br_disp[31];
								s_nxt.pbit   = br_bit;
								s_nxt.psense = br_sense;
								s_nxt.alt    = s_nxt.pred ? seq : tgt;
								s_nxt.redir  = 1'b1;
								s_nxt.faddr  = s_nxt.pred ? tgt : seq;
								s_nxt.st     = btf_pkg::ST_BWAIT;
							end
						end
						btf_pkg::OP_CRL, btf_pkg::OP_MCRF: begin
							if (br_lk) begin
								s_nxt.inval = 1'b1;
							end else begin
								s_nxt.pmove = (op_kind == btf_pkg::OP_MCRF);
								s_nxt.pfn   = cr_fn;
								s_nxt.pa    = src_cr_a;
								s_nxt.pb    = src_cr_b;
								s_nxt.pd    = dest_cr_bit;
								s_nxt.st    = btf_pkg::ST_CWAIT;
							end
						end
						btf_pkg::OP_TRAP: begin
							s_nxt.trap = t_hit;
						end
						default: begin
						end
					endcase
				end
			end
			btf_pkg::ST_BWAIT: begin
				if (!cr_busy[s_r.pbit]) begin
					s_nxt.st   = btf_pkg::ST_IDLE;
					s_nxt.done = 1'b1;
					if ((condition_register[s_r.pbit] == s_r.psense) != s_r.pred) begin
						s_nxt.purge = 1'b1;
						s_nxt.redir = 1'b1;
						s_nxt.faddr = s_r.alt;
					end
				end
			end
			btf_pkg::ST_CWAIT: begin
				// serialised: held until older work completes
				if (prior_done) begin
					s_nxt.cr_we    = 1'b1;
					s_nxt.cr_wdata = cr_nx;
					s_nxt.st       = btf_pkg::ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = btf_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_r       <= '0;
			s_r.st    <= btf_pkg::ST_IDLE;
			s_r.faddr <= btf_pkg::RST_ADDR;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign fpr_we         = s_r.fpr_we;
	assign fpr_widx       = s_r.fpr_widx;
	assign fpr_wdata      = s_r.fpr_wdata;
	assign mem_rd         = s_r.mem_rd;
	assign mem_wr         = s_r.mem_wr;
	assign mem_dbl        = s_r.mem_dbl;
	assign mem_addr       = s_r.mem_addr;
	assign mem_wdata      = s_r.mem_wdata;
	assign gpr_we         = s_r.gpr_we;
	assign gpr_widx       = s_r.gpr_widx;
	assign gpr_wdata      = s_r.gpr_wdata;
	assign fetch_redirect = s_r.redir;
	assign fetch_addr     = s_r.faddr;
	assign purge          = s_r.purge;
	assign br_done        = s_r.done;
	assign lr_we          = s_r.lr_we;
	assign lr_wdata       = s_r.lr_wdata;
	assign cr_we          = s_r.cr_we;
	assign cr_wdata       = s_r.cr_wdata;
	assign invalid_form   = s_r.inval;
	assign trap_take      = s_r.trap;
endmodule : btf_unit

`default_nettype wire

// file: src/btf_pkg.sv
// shared constants and types for the branch, trap and float memory unit
package btf_pkg;
	localparam int unsigned XLEN      = 32;
	localparam int unsigned FLEN      = 64;
	// float formats
	localparam logic [10:0] DP_EXP_MAX  = 11'h7ff;
	localparam logic [7:0]  SP_EXP_MAX  = 8'hff;
	localparam logic [10:0] EXP_REBIAS  = 11'h380;
	localparam logic [10:0] SP_EXP_LO   = 11'h381;
	localparam logic [10:0] SP_EXP_HI   = 11'h47e;
	localparam logic [10:0] SP_DEN_LO   = 11'h36a;
	localparam logic [4:0]  SP_MAN_W    = 5'h17;
	// address alignment
	localparam logic [31:0] WORD_MASK   = 32'hffff_fffc;
	// trap mask bit positions
	localparam int unsigned TO_SLT = 4;
	localparam int unsigned TO_SGT = 3;
	localparam int unsigned TO_EQ  = 2;
	localparam int unsigned TO_ULT = 1;
	localparam int unsigned TO_UGT = 0;
	// reset values
	localparam logic [31:0] RST_ADDR = 32'h0000_0000;

	typedef enum logic [3:0] {
		OP_NONE  = 4'h0,
		OP_LFD   = 4'h1,
		OP_LFS   = 4'h2,
		OP_STFD  = 4'h3,
		OP_STFS  = 4'h4,
		OP_STFIW = 4'h5,
		OP_BR    = 4'h6,
		OP_CRL   = 4'h7,
		OP_MCRF  = 4'h8,
		OP_TRAP  = 4'h9
	} btf_op_e;

	typedef enum logic [2:0] {
		BF_REL   = 3'h0,
		BF_ABS   = 3'h1,
		BF_CREL  = 3'h2,
		BF_CABS  = 3'h3,
		BF_CLR   = 3'h4,
		BF_CCTR  = 3'h5
	} btf_bform_e;

	typedef enum logic [2:0] {
		CL_AND  = 3'h0,
		CL_ANDC = 3'h1,
		CL_EQV  = 3'h2,
		CL_NAND = 3'h3,
		CL_NOR  = 3'h4,
		CL_OR   = 3'h5,
		CL_ORC  = 3'h6,
		CL_XOR  = 3'h7
	} btf_crfn_e;

	// gray sequence idle -> branch wait -> cr wait
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_BWAIT = 2'b01,
		ST_CWAIT = 2'b11
	} btf_state_e;
endpackage : btf_pkg

// file: testbench/btf_pipe_model.sv
// pipeline partner: keeps cr bits busy and older work pending for a while
`timescale 1ns/100ps
`default_nettype none
module btf_pipe_model (
	// clock
	input  wire logic       clock,
	// hold request from the bench
	input  wire logic       hold_go,
	input  wire logic [7:0] hold_len,
	// toward the unit
	output logic [31:0]     cr_busy,
	output logic            prior_done
);
	logic [7:0] left_r;

	initial left_r = 8'h00;
	// whole cr looks busy while a writer is in flight, so any tested bit interlocks
	always @(posedge clock) begin
		if (hold_go)
			left_r <= hold_len;
		else if (left_r != 8'h00)
			left_r <= left_r - 8'h01;
	end
	assign cr_busy    = {32{left_r != 8'h00}};
	assign prior_done = (left_r == 8'h00);
endmodule : btf_pipe_model
`default_nettype wire

// file: testbench/btf_unit_assertions.sv
// port checker for the branch, trap and float memory unit
`timescale 1ns/100ps
`default_nettype none
module btf_unit_assertions (
	// clock, reset and issue
	input wire logic                clock,
	input wire logic                reset,
	input wire logic                clk_en,
	input wire logic                op_valid,
	input wire btf_pkg::btf_op_e    op_kind,
	input wire logic                op_ready,
	// operands
	input wire logic                op_update,
	input wire logic [31:0]         base_val,
	input wire logic [31:0]         index_val,
	input wire logic [63:0]         fpr_rdata,
	input wire logic [63:0]         mem_rdata,
	input wire btf_pkg::btf_bform_e br_form,
	input wire logic                br_lk,
	input wire logic [4:0]          br_bit,
	input wire logic [31:0]         cia,
	input wire logic [31:0]         cr_busy,
	input wire logic                prior_done,
	// results
	input wire logic                fpr_we,
	input wire logic [63:0]         fpr_wdata,
	input wire logic                mem_wr,
	input wire logic [63:0]         mem_wdata,
	input wire logic                gpr_we,
	input wire logic [31:0]         gpr_wdata,
	input wire logic                fetch_redirect,
	input wire logic                purge,
	input wire logic                br_done,
	input wire logic                lr_we,
	input wire logic [31:0]         lr_wdata,
	input wire logic                cr_we,
	input wire logic                invalid_form
);
	logic        take;
	logic [10:0] dexp;

	assign take = clk_en && op_valid && op_ready;
	assign dexp = fpr_rdata[62:52];
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// normal singles only: denormals need a shift
	a_widen_single: assert property (take && op_kind == btf_pkg::OP_LFS
		&& mem_rdata[30:23] != 8'h00 && mem_rdata[30:23] != 8'hff |=> fpr_we && fpr_wdata ==
		{$past(mem_rdata[31:30]), {3{!$past(mem_rdata[30])}}, $past(mem_rdata[29:0]), 29'h0})
		else $error("single load not widened");
	a_narrow_single: assert property (take && op_kind == btf_pkg::OP_STFS
		&& dexp >= btf_pkg::SP_EXP_LO && dexp <= btf_pkg::SP_EXP_HI |=> mem_wr && mem_wdata ==
		{32'h0, $past(fpr_rdata[63:62]), $past(fpr_rdata[58:29])})
		else $error("single store not narrowed");
	a_update_zero: assert property (take && op_update && op_kind inside
		{btf_pkg::OP_LFD, btf_pkg::OP_LFS, btf_pkg::OP_STFD, btf_pkg::OP_STFS} |=> gpr_we
		&& !invalid_form && gpr_wdata == $past(base_val) + $past(index_val))
		else $error("update form not executed");
	a_unresolved_wait: assert property (take && op_kind == btf_pkg::OP_BR && cr_busy[br_bit]
		&& br_form inside {btf_pkg::BF_CREL, btf_pkg::BF_CABS} |=> fetch_redirect && !op_ready
		&& !br_done) else $error("interlocked branch not predicted");
	a_purge_redirect: assert property (purge |-> fetch_redirect && br_done)
		else $error("purge without refetch");
	a_link_next: assert property (take && op_kind == btf_pkg::OP_BR && br_lk
		|=> lr_we && lr_wdata == $past(cia) + 32'h4) else $error("link not written");
	a_serial_wait: assert property (cr_we |-> $past(prior_done) && !$past(op_ready))
		else $error("cr write before older work done");
	a_link_invalid: assert property (take && br_lk
		&& op_kind inside {btf_pkg::OP_CRL, btf_pkg::OP_MCRF} |=> invalid_form && !cr_we)
		else $error("cr op with link option accepted");

	c_late_purge: cover property (purge);
	c_cr_write: cover property (cr_we);
	c_refused_form: cover property (invalid_form);
endmodule : btf_unit_assertions
`default_nettype wire

// file: testbench/btf_unit_tb.sv
// bench for the branch, trap and float memory unit
`timescale 1ns/100ps
`default_nettype none
module btf_unit_tb;
	// stimulus
	logic clock = 1'b0, reset = 1'b1, clk_en = 1'b1, op_valid = 1'b0, op_update = 1'b0;
	logic br_aa = 1'b0, br_lk = 1'b0, br_sense = 1'b1, trap_imm = 1'b0, hold_go = 1'b0;
	logic [4:0] base_gpr = 5'h0, fpr_idx = 5'h0, br_bit = 5'h2, src_cr_a = 5'h0;
	logic [4:0] src_cr_b = 5'h0, dest_cr_bit = 5'h0, trap_condition_mask = 5'h0;
	logic [7:0] hold_len = 8'h04;
	logic [15:0] signed_immediate = 16'h0;
	logic [31:0] base_val = 32'h0, index_val = 32'h0, br_disp = 32'h0, cia = 32'h1000;
	logic [31:0] link_register = 32'h3003, count_reg = 32'h4006, condition_register = 32'h0;
	logic [63:0] fpr_rdata = 64'h0, mem_rdata = 64'h0;
	btf_pkg::btf_op_e op_kind = btf_pkg::OP_NONE;
	btf_pkg::btf_bform_e br_form = btf_pkg::BF_REL;
	btf_pkg::btf_crfn_e cr_fn = btf_pkg::CL_AND;
	// observed
	logic op_ready, fpr_we, mem_rd, mem_wr, mem_dbl, gpr_we, fetch_redirect, purge, br_done;
	logic lr_we, cr_we, invalid_form, trap_take, prior_done;
	logic [4:0] fpr_widx, gpr_widx;
	logic [31:0] mem_addr, gpr_wdata, fetch_addr, lr_wdata, cr_wdata, cr_busy;
	logic [63:0] fpr_wdata, mem_wdata;
	int failures = 0;
	int checks = 0;

	btf_unit       u_dut (.*);
	btf_pipe_model u_pipe (.*);

	always #4 clock = ~clock;

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	// one op for one edge; returns when its results are visible
	task automatic issue(input btf_pkg::btf_op_e k);
		@(negedge clock);
		op_kind = k;
		op_valid = 1'b1;
		@(negedge clock);
		op_valid = 1'b0;
	endtask : issue

	// bounded wait for a late branch or cr result
	task automatic wait_for(input logic want_cr);
		int n;
		n = 0;
		while ((want_cr ? cr_we : br_done) !== 1'b1) begin
			if (n == 30) begin
				failures++;
				give_verdict();
			end
			n++;
			@(negedge clock);
		end
	endtask : wait_for

	task automatic hold(input logic [7:0] len);
		hold_len = len;
		hold_go = 1'b1;
		@(negedge clock);
		hold_go = 1'b0;
	endtask : hold

	task automatic s_float_memops;
		op_update = 1'b1;
		base_val = 32'h100;
		index_val = 32'h8;
		fpr_idx = 5'h07;
		mem_rdata = 64'h3f80_0000;
		issue(btf_pkg::OP_LFS);
		chk(fpr_wdata, 64'h3ff0_0000_0000_0000);
		chk({fpr_we, fpr_widx, mem_rd}, {1'b1, 5'h07, 1'b1});
		chk({gpr_we, gpr_widx, invalid_form, gpr_wdata}, {7'h40, 32'h108});
		mem_rdata = 64'hc000_0000_0000_0001;
		issue(btf_pkg::OP_LFD);
		chk(fpr_wdata, 64'hc000_0000_0000_0001);
		fpr_rdata = 64'h4000_0000_1234_5678;
		issue(btf_pkg::OP_STFS);
		chk({mem_wr, mem_dbl, gpr_we, invalid_form, mem_addr}, {4'ha, 32'h108});
		chk(mem_wdata, 64'h4000_0000);
		issue(btf_pkg::OP_STFD);
		chk({mem_dbl, mem_wdata}, {1'b1, fpr_rdata});
		issue(btf_pkg::OP_STFIW);
		chk({mem_wr, gpr_we, mem_wdata}, {2'b10, 64'h1234_5678});
		op_update = 1'b0;
	endtask : s_float_memops

	task automatic br_try(input btf_pkg::btf_bform_e f, input logic aa,
			input logic [31:0] d, input logic [31:0] exp);
		br_form = f;
		br_aa = aa;
		br_disp = d;
		issue(btf_pkg::OP_BR);
		chk({fetch_redirect, fetch_addr}, {1'b1, exp});
		chk({lr_we, lr_wdata}, {1'b1, 32'h1004});
		chk({purge, op_ready}, 2'b01);
	endtask : br_try

	task automatic s_branch_now;
		condition_register = 32'h4;
		br_lk = 1'b1;
		br_try(btf_pkg::BF_REL, 1'b0, 32'h103, 32'h1100);
		br_try(btf_pkg::BF_REL, 1'b1, 32'h103, 32'h100);
		br_try(btf_pkg::BF_ABS, 1'b0, 32'h2002, 32'h2000);
		br_try(btf_pkg::BF_CREL, 1'b0, 32'hff, 32'h10fc);
		br_try(btf_pkg::BF_CABS, 1'b0, 32'h5001, 32'h5000);
		br_try(btf_pkg::BF_CLR, 1'b0, 32'h0, 32'h3000);
		br_try(btf_pkg::BF_CCTR, 1'b0, 32'h0, 32'h4004);
		br_lk = 1'b0;
	endtask : s_branch_now

	// cr bit flips while the branch waits: resolution must use the late value
	task automatic s_branch_late(input logic [31:0] d, input logic fin,
			input logic [31:0] pred, input logic [31:0] last, input logic bad);
		br_form = btf_pkg::BF_CREL;
		br_disp = d;
		condition_register = {29'h0, !fin, 2'h0};
		hold(8'h04);
		issue(btf_pkg::OP_BR);
		chk({fetch_redirect, fetch_addr, op_ready}, {1'b1, pred, 1'b0});
		condition_register = {29'h0, fin, 2'h0};
		wait_for(1'b0);
		chk({br_done, purge, fetch_redirect, fetch_addr}, {1'b1, bad, bad, last});
	endtask : s_branch_late

	task automatic s_cr_ops;
		logic [7:0] res [3] = '{8'hea, 8'ha8, 8'h65};
		logic [4:0] ia [3] = '{5'h1, 5'h0, 5'h1};
		logic [4:0] ib [3] = '{5'h0, 5'h1, 5'h3};
		condition_register = 32'ha;
		dest_cr_bit = 5'h1e;
		for (int c = 0; c < 3; c++) begin
			for (int f = 0; f < 8; f++) begin
				cr_fn = btf_pkg::btf_crfn_e'(f);
				src_cr_a = ia[c];
				src_cr_b = ib[c];
				hold(8'h04);
				issue(btf_pkg::OP_CRL);
				chk({op_ready, cr_we}, 2'b00);
				wait_for(1'b1);
				chk(cr_wdata, {1'b0, res[c][f], 30'ha});
			end
		end
		condition_register = 32'ha00;
		src_cr_a = 5'h2;
		dest_cr_bit = 5'h0;
		issue(btf_pkg::OP_MCRF);
		wait_for(1'b1);
		chk(cr_wdata, 32'ha0a);
		br_lk = 1'b1;
		issue(btf_pkg::OP_CRL);
		chk({invalid_form, cr_we}, 2'b10);
		issue(btf_pkg::OP_MCRF);
		chk({invalid_form, cr_we}, 2'b10);
		br_lk = 1'b0;
	endtask : s_cr_ops

	task automatic trap_try(input logic [4:0] m, input logic imm, input logic [31:0] a,
			input logic [31:0] b, input logic exp);
		trap_condition_mask = m;
		trap_imm = imm;
		base_val = a;
		index_val = b;
		signed_immediate = b[15:0];
		issue(btf_pkg::OP_TRAP);
		chk(trap_take, exp);
	endtask : trap_try

	task automatic s_traps;
		logic [4:0] want = 5'h11;
		for (int i = 0; i < 5; i++)
			trap_try(5'h01 << i, 1'b0, 32'hffff_ffff, 32'h1, want[i]);
		trap_try(5'h00, 1'b0, 32'h7, 32'h7, 1'b0);
		trap_try(5'h04, 1'b0, 32'h7, 32'h7, 1'b1);
		trap_try(5'h08, 1'b1, 32'h5, 32'hfffe, 1'b1);
		trap_try(5'h01, 1'b1, 32'h5, 32'hfffe, 1'b0);
		trap_try(5'h02, 1'b1, 32'h5, 32'hfffe, 1'b1);
	endtask : s_traps

	// frozen clock enable drops the op; a mid-run reset clears held outputs
	task automatic s_freeze_reset;
		mem_rdata = 64'h4080_0000;
		clk_en = 1'b0;
		issue(btf_pkg::OP_LFS);
		chk({fpr_we, fpr_wdata}, {1'b0, 64'hc000_0000_0000_0001});
		clk_en = 1'b1;
		reset = 1'b1;
		@(negedge clock);
		reset = 1'b0;
		chk({op_ready, trap_take, fetch_addr}, {2'b10, 32'h0});
		chk(fpr_wdata, 64'h0);
		issue(btf_pkg::OP_LFS);
		chk(fpr_wdata, 64'h4010_0000_0000_0000);
	endtask : s_freeze_reset

	initial begin
		repeat (10) @(negedge clock);
		reset = 1'b0;
		s_float_memops();
		s_branch_now();
		s_branch_late(32'hffff_ff00, 1'b1, 32'hf00, 32'hf00, 1'b0);
		s_branch_late(32'hffff_ff00, 1'b0, 32'hf00, 32'h1004, 1'b1);
		s_branch_late(32'h100, 1'b1, 32'h1004, 32'h1100, 1'b1);
		s_cr_ops();
		s_traps();
		s_freeze_reset();
		give_verdict();
	end
endmodule : btf_unit_tb

bind btf_unit btf_unit_assertions u_chk (.*);
`default_nettype wire
